// ### dv/dwb_bus_master.sv
// bus master model: makes the serial clock and pulls the data wire low
// assumes a pull-up on the wire and a link tick clock from the bench
`timescale 1ns/10ps

module dwb_bus_master (
  input  wire logic link_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge link_clk_i);
  endtask : tk

  // start is cond(0,1), stop is cond(1,0); the clock stands high after stop
  task automatic cond(input logic a, input logic b);
    sda_low_o <= a;
    tk(1);
    scl_o <= 1'b1;
    tk(3);
    sda_low_o <= b;
    tk(3);
    scl_o <= ~b;
    tk(2);
  endtask : cond

  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_o <= ~b;
    tk(1);
    scl_o <= 1'b1;
    tk(3);
    r = sda_i;
    scl_o <= 1'b0;
    tk(2);
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : dwb_bus_master

// ### dv/testbench.sv
// self-checking bench for the dual wiper bank driven by the bus master model
// assumes hw/ on the include path and a pull-up on the data wire
`timescale 1ns/10ps
`include "dwb_params.svh"

module testbench;
  logic        clock_i;
  logic        reset_i;
  logic        link_clk;
  logic        scl;
  logic        m_low;
  logic        sda_o;
  logic        sda_oe_o;
  logic [3:0]  bus_id;
  logic [63:0] tap0;
  logic [63:0] tap1;
  wire         sda = ~(sda_oe_o | m_low);
  int          err_count = 0;
  int          checked   = 0;
  int          gap       = 450;
  logic [31:0] seed      = 32'h600A494B;
  logic [5:0]  wx [2];
  logic [5:0]  sx [2][4];
  logic [5:0]  v;

  dwb_wiper_bank #(.NV_WRITE_CYCLES(400)) dwb_wiper_bank_i (
    .clock_i(clock_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .bus_id_i(bus_id), .tap0_o(tap0), .tap1_o(tap1));
  dwb_bus_master dwb_bus_master_i (
    .link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [5:0] f_step(input logic [5:0] w, input logic up);
    if (up) return (w == 6'h3F) ? w : w + 6'h01;
    return (w == 6'h00) ? w : w - 6'h01;
  endfunction : f_step

  task automatic chk_v(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_b

  task automatic chk_taps();
    repeat (3) @(posedge clock_i);
    chk_v(tap0, 64'h1 << wx[0]);
    chk_v(tap1, 64'h1 << wx[1]);
  endtask : chk_taps

  task automatic frame(input logic [3:0] op, input logic pot, input logic [1:0] idx,
                       input logic [7:0] d, input int n, input logic [3:0] id, input logic e);
    logic a;
    dwb_bus_master_i.cond(1'b0, 1'b1);
    dwb_bus_master_i.wr_byte({`DWB_ADDR_PREFIX, id, 1'b0}, a);
    chk_b(a, e);
    dwb_bus_master_i.wr_byte({op, idx, 1'b0, pot}, a);
    for (int i = 0; i < n; i++) dwb_bus_master_i.wr_byte(d, a);
    dwb_bus_master_i.cond(1'b1, 1'b0);
    repeat (gap) @(posedge clock_i);
  endtask : frame

  task automatic rd(input logic [3:0] op, input logic pot, input logic [1:0] idx,
                    input logic [5:0] e);
    logic       a;
    logic [7:0] d;
    frame(op, pot, idx, 8'h00, 0, bus_id, 1'b1);
    dwb_bus_master_i.cond(1'b0, 1'b1);
    dwb_bus_master_i.wr_byte({`DWB_ADDR_PREFIX, bus_id, 1'b1}, a);
    dwb_bus_master_i.rd_byte(1'b1, d);
    dwb_bus_master_i.cond(1'b1, 1'b0);
    chk_b(a, 1'b1);
    chk_v({56'h0, d}, {58'h0, e});
  endtask : rd

  task automatic rst();
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clock_i);
  endtask : rst

  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clock_i) if (sda_oe_o === 1'b1) chk_b(sda_o, 1'b0);

  initial begin
    #500000;
    err_count++;
    end_of_test();
  end

  initial begin
    reset_i = 1'b1;
    bus_id  = 4'(xs());
    rst();
    for (int p = 0; p < 2; p++) for (int k = 0; k < 4; k++) begin
      sx[p][k] = (k == 3) ? {6{p[0]}} : 6'(xs());
      frame(`DWB_OP_WR_STORED, 1'(p), 2'(k), {2'b11, sx[p][k]}, 1, bus_id, 1'b1);
      rd(`DWB_OP_RD_STORED, 1'(p), 2'(k), sx[p][k]);
    end
    rst();
    wx[0] = sx[0][0];
    wx[1] = sx[1][0];
    chk_taps();
    for (int i = 0; i < 4; i++) begin
      wx[i%2] = (i < 2) ? {6{i[0]}} : 6'(xs());
      frame(`DWB_OP_WR_WIPER, i[0], 2'h0, {2'b10, wx[i%2]}, 1, bus_id, 1'b1);
      chk_taps();
      rd(`DWB_OP_RD_WIPER, i[0], 2'h0, wx[i%2]);
      v = 6'(xs());
      frame(`DWB_OP_RECALL, i[0], v[1:0], 8'h00, 0, bus_id, 1'b1);
      wx[i%2] = sx[i%2][v[1:0]];
      chk_taps();
    end
    frame(`DWB_OP_SAVE, 1'b0, 2'h2, 8'h00, 0, bus_id, 1'b1);
    sx[0][2] = wx[0];
    rd(`DWB_OP_RD_STORED, 1'b0, 2'h2, sx[0][2]);
    for (int p = 0; p < 2; p++) begin
      wx[p] = p ? 6'h01 : 6'h3E;
      frame(`DWB_OP_WR_WIPER, 1'(p), 2'h0, {2'b00, wx[p]}, 1, bus_id, 1'b1);
      frame(`DWB_OP_INCDEC, 1'(p), 2'h0, {7'h00, ~p[0]}, 3, bus_id, 1'b1);
      repeat (3) wx[p] = f_step(wx[p], ~p[0]);
      chk_taps();
    end
    gap = 0;
    frame(`DWB_OP_WR_STORED, 1'b1, 2'h1, 8'h15, 1, bus_id, 1'b1);
    gap = 450;
    frame(`DWB_OP_WR_WIPER, 1'b1, 2'h0, 8'h2A, 1, bus_id, 1'b0);
    chk_taps();
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      bus_id <= 4'(xs());
      repeat (8) @(posedge clock_i);
      frame(`DWB_OP_WR_WIPER, 1'b0, 2'h0, 8'h07, 1, bus_id ^ (4'h1 << i), 1'b0);
      chk_taps();
      wx[0] = 6'(xs());
      frame(`DWB_OP_WR_WIPER, 1'b0, 2'h0, {2'b00, wx[0]}, 1, bus_id, 1'b1);
      chk_taps();
    end
    end_of_test();
  end
endmodule : testbench

// ### hw/dwb_params.svh
// constants of the dual wiper register bank: address, opcodes, timing
// assumes inclusion by the bank module; definitions only
`ifndef DWB_PARAMS_SVH
`define DWB_PARAMS_SVH

// fixed upper part of the 7-bit slave address, pins supply the low four
`define DWB_ADDR_PREFIX   3'h5

// instruction opcodes, upper nibble of the instruction byte
`define DWB_OP_INCDEC     4'h2
`define DWB_OP_RD_WIPER   4'h9
`define DWB_OP_WR_WIPER   4'hA
`define DWB_OP_RD_STORED  4'hB
`define DWB_OP_WR_STORED  4'hC
`define DWB_OP_RECALL     4'hD
`define DWB_OP_SAVE       4'hE

// reset values and wiper upper limit
`define DWB_WIPER_RST     6'h00
`define DWB_WIPER_MAX     6'h3F
`define DWB_TAP_RST       64'h0000_0000_0000_0001

// bit counter positions within a byte frame
`define DWB_BIT_LAST      4'h7
`define DWB_BIT_ACK       4'h8

// timing
`define DWB_CLK_MHZ       200
`define DWB_NV_WRITE_US   5000

`endif

// ### hw/dwb_pkg.sv
// types shared by the dual wiper register bank
// assumes nothing beyond a SystemVerilog compiler
package dwb_pkg;

  typedef enum logic [2:0] {
    DWB_ST_IDLE   = 3'b000,
    DWB_ST_ADDR   = 3'b001,
    DWB_ST_INSTR  = 3'b010,
    DWB_ST_DATA   = 3'b011,
    DWB_ST_READ   = 3'b100,
    DWB_ST_IGNORE = 3'b101
  } dwb_state_e;

  // instruction byte as sent after the address byte
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] idx;
    logic       rsv;
    logic       pot;
  } dwb_instr_s;

  // synchronised pin levels
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [3:0] bus_id;
  } dwb_pins_s;

endpackage : dwb_pkg

// ### hw/dwb_wiper_bank.sv
// dual wiper register bank: two 6-bit wipers, eight stored settings, serial slave
// assumes an open-drain bus resolved outside; scl_i is made by the bus master
//
// Notes on behaviour
// - two independent 6-bit wiper position registers
// - four stored 6-bit settings per wiper
// - power-up copies first stored setting to wiper
// - exactly one tap selected per wiper
// - four id pins form low address bits
// - respond only when sent address matches pins
// - data line only pulled low or released
// - incoming serial bytes shifted in on master clock, outgoing bits driven on clock_i
// - master reads and writes wipers and stored settings
// - copy between wiper and its stored settings
// - increment/decrement mode steps the wiper
`timescale 1ns/10ps
`include "dwb_params.svh"

module dwb_wiper_bank #(
  parameter int unsigned NV_WRITE_CYCLES = `DWB_NV_WRITE_US * `DWB_CLK_MHZ,
  parameter logic [2:0]  ADDR_PREFIX     = `DWB_ADDR_PREFIX
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic [3:0]  bus_id_i,
  output logic      [63:0] tap0_o,
  output logic      [63:0] tap1_o
);

  if (NV_WRITE_CYCLES < 1) begin : g_chk_nv
    $error("NV_WRITE_CYCLES must be at least one");
  end

  function automatic logic [63:0] dwb_tap_sel(input logic [5:0] pos);
    return 64'h0000_0000_0000_0001 << pos;
  endfunction : dwb_tap_sel

  // link domain: byte shifter on the master's clock, free running
  logic [7:0] link_shift_q;
  logic [7:0] link_shift_d;

  always_comb begin
    link_shift_d = {link_shift_q[6:0], sda_i};
  end

  always_ff @(posedge scl_i) begin
    link_shift_q <= link_shift_d;
  end

  // pin synchronisers, stage one read only by stage two
  dwb_pkg::dwb_pins_s pins_a_q, pins_b_q, pins_c_q;
  dwb_pkg::dwb_pins_s pins_a_d, pins_b_d, pins_c_d;

  always_comb begin
    pins_a_d = '{scl: scl_i, sda: sda_i, bus_id: bus_id_i};
    pins_b_d = pins_a_q;
    pins_c_d = pins_b_q;
  end

  always_ff @(posedge clock_i) begin
    pins_a_q <= pins_a_d;
    pins_b_q <= pins_b_d;
    pins_c_q <= pins_c_d;
  end

  logic       scl_rise, scl_fall, bus_start, bus_stop, byte_done;
  logic [7:0] byte_w;
  logic [6:0] own_addr;

  always_comb begin
    scl_rise  = pins_b_q.scl & ~pins_c_q.scl;
    scl_fall  = ~pins_b_q.scl & pins_c_q.scl;
    bus_start = pins_b_q.scl & pins_c_q.scl & pins_c_q.sda & ~pins_b_q.sda;
    bus_stop  = pins_b_q.scl & pins_c_q.scl & ~pins_c_q.sda & pins_b_q.sda;
    // shifter is stable from one master rising edge to the next
    byte_w    = link_shift_q;
    own_addr  = {ADDR_PREFIX, pins_b_q.bus_id};
  end

  // protocol and register state
  dwb_pkg::dwb_state_e st_q, st_d;
  dwb_pkg::dwb_instr_s ins_q, ins_d, ins_w;
  logic [3:0]          bit_q, bit_d;
  logic                ack_q, ack_d;
  logic                oe_q, oe_d;
  logic                sda_lo_q;
  logic [7:0]          tx_q, tx_d;
  logic [31:0]         busy_q, busy_d;
  logic                recall_q;
  logic [5:0]          wiper_q [2];
  logic [5:0]          wiper_d [2];
  // erased contents before the first write, so a first power-up recalls a known tap
  logic [5:0]          stored_q [2][4] = '{default: `DWB_WIPER_RST};
  logic [5:0]          stored_d [2][4];
  logic [63:0]         tap0_q, tap1_q;
  logic [5:0]          rd_val;

  always_comb begin
    ins_w  = dwb_pkg::dwb_instr_s'(byte_w);
    rd_val = (ins_q.op == `DWB_OP_RD_STORED) ? stored_q[ins_q.pot][ins_q.idx]
                                              : wiper_q[ins_q.pot];
  end

  always_comb begin
    st_d     = st_q;
    bit_d    = bit_q;
    ack_d    = ack_q;
    oe_d     = oe_q;
    ins_d    = ins_q;
    tx_d     = tx_q;
    wiper_d  = wiper_q;
    stored_d = stored_q;
    busy_d   = (busy_q != 32'h0000_0000) ? busy_q - 32'h0000_0001 : busy_q;
    if (recall_q) begin
      for (int p = 0; p < 2; p++) begin
        wiper_d[p] = stored_q[p][0];
      end
    end
    if (bus_start) begin
      st_d  = dwb_pkg::DWB_ST_ADDR;
      bit_d = 4'h0;
      ack_d = 1'b0;
      oe_d  = 1'b0;
    end else if (bus_stop) begin
      st_d  = dwb_pkg::DWB_ST_IDLE;
      bit_d = 4'h0;
      ack_d = 1'b0;
      oe_d  = 1'b0;
    end else if (scl_rise && st_q != dwb_pkg::DWB_ST_IDLE) begin
      if (bit_q == `DWB_BIT_ACK) begin
        bit_d = 4'h0;
        // master not acknowledging ends the read
        if (st_q == dwb_pkg::DWB_ST_READ && pins_b_q.sda) begin
          st_d = dwb_pkg::DWB_ST_IGNORE;
        end
      end else begin
        bit_d = bit_q + 4'h1;
      end
      if (bit_q == `DWB_BIT_LAST) begin
        ack_d = 1'b0;
        case (st_q)
          dwb_pkg::DWB_ST_ADDR: begin
            if (byte_w[7:1] == own_addr && busy_q == 32'h0000_0000) begin
              ack_d = 1'b1;
              if (byte_w[0]) begin
                st_d = dwb_pkg::DWB_ST_READ;
                tx_d = {2'h0, rd_val};
              end else begin
                st_d = dwb_pkg::DWB_ST_INSTR;
              end
            end else begin
              st_d = dwb_pkg::DWB_ST_IGNORE;
            end
          end
          dwb_pkg::DWB_ST_INSTR: begin
            ack_d = 1'b1;
            ins_d = ins_w;
            st_d  = dwb_pkg::DWB_ST_DATA;
            case (ins_w.op)
              `DWB_OP_RECALL: wiper_d[ins_w.pot] = stored_q[ins_w.pot][ins_w.idx];
              `DWB_OP_SAVE: begin
                stored_d[ins_w.pot][ins_w.idx] = wiper_q[ins_w.pot];
                busy_d = NV_WRITE_CYCLES;
              end
              default: ;
            endcase
          end
          dwb_pkg::DWB_ST_DATA: begin
            ack_d = 1'b1;
            case (ins_q.op)
              `DWB_OP_WR_WIPER: wiper_d[ins_q.pot] = byte_w[5:0];
              `DWB_OP_WR_STORED: begin
                stored_d[ins_q.pot][ins_q.idx] = byte_w[5:0];
                busy_d = NV_WRITE_CYCLES;
              end
              `DWB_OP_INCDEC: begin
                // bit 0 high steps up, low steps down, ends saturate
                if (byte_w[0] && wiper_q[ins_q.pot] != `DWB_WIPER_MAX) begin
                  wiper_d[ins_q.pot] = wiper_q[ins_q.pot] + 6'h01;
                end else if (!byte_w[0] && wiper_q[ins_q.pot] != 6'h00) begin
                  wiper_d[ins_q.pot] = wiper_q[ins_q.pot] - 6'h01;
                end
              end
              default: ;
            endcase
            if (busy_d != 32'h0000_0000 && ins_q.op == `DWB_OP_WR_STORED) begin
              st_d = dwb_pkg::DWB_ST_IGNORE;
            end
          end
          dwb_pkg::DWB_ST_READ: tx_d = {2'h0, rd_val};
          default: ;
        endcase
      end
    end else if (scl_fall) begin
      if (bit_q == `DWB_BIT_ACK) begin
        oe_d = ack_q;
      end else if (st_q == dwb_pkg::DWB_ST_READ) begin
        oe_d = ~tx_q[3'(`DWB_BIT_LAST - bit_q)];
      end else begin
        oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_q     <= dwb_pkg::DWB_ST_IDLE;
      bit_q    <= 4'h0;
      ack_q    <= 1'b0;
      oe_q     <= 1'b0;
      sda_lo_q <= 1'b0;
      ins_q    <= '0;
      tx_q     <= 8'h00;
      busy_q   <= 32'h0000_0000;
      recall_q <= 1'b1;
      wiper_q  <= '{`DWB_WIPER_RST, `DWB_WIPER_RST};
      tap0_q   <= `DWB_TAP_RST;
      tap1_q   <= `DWB_TAP_RST;
    end else begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      ack_q    <= ack_d;
      oe_q     <= oe_d;
      sda_lo_q <= 1'b0;
      ins_q    <= ins_d;
      tx_q     <= tx_d;
      busy_q   <= busy_d;
      recall_q <= 1'b0;
      wiper_q  <= wiper_d;
      tap0_q   <= dwb_tap_sel(wiper_q[0]);
      tap1_q   <= dwb_tap_sel(wiper_q[1]);
    end
  end

  // stored settings keep their contents through reset
  always_ff @(posedge clock_i) begin
    stored_q <= stored_d;
  end

  always_comb begin
    sda_o    = sda_lo_q;
    sda_oe_o = oe_q;
    tap0_o   = tap0_q;
    tap1_o   = tap1_q;
  end

  // checks
  default clocking dwb_cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);

  always_comb begin
    byte_done = scl_rise && bit_q == `DWB_BIT_LAST;
  end

  AST_TAP_ONEHOT: assert property ($onehot(tap0_q) && $onehot(tap1_q))
    else $error("tap select not one-hot");

  AST_TAP_FOLLOWS: assert property (tap1_q == dwb_tap_sel($past(wiper_q[1])))
    else $error("tap select does not follow wiper");

  AST_POWERUP: assert property (recall_q && !reset_i |=> wiper_q[1] == $past(stored_q[1][0]))
    else $error("wiper not recalled at power-up");

  AST_SDA_LOW_ONLY: assert property (sda_o_check(sda_lo_q))
    else $error("data line driven high");

  AST_ADDR_MISMATCH: assert property ((byte_done && st_q == dwb_pkg::DWB_ST_ADDR
      && byte_w[7:1] != own_addr) |=> st_q == dwb_pkg::DWB_ST_IGNORE && !ack_q)
    else $error("foreign address accepted");

  AST_BUSY_SILENT: assert property ((busy_q != 32'h0000_0000 && byte_done
      && st_q == dwb_pkg::DWB_ST_ADDR) |=> !ack_q ##1 !ack_q)
    else $error("address acknowledged during stored write");

  AST_ACK_DRIVE: assert property ((scl_fall && bit_q == `DWB_BIT_ACK && ack_q)
      |=> oe_q && sda_oe_o)
    else $error("acknowledge not driven");

  AST_WIPER_WRITE: assert property ((byte_done && st_q == dwb_pkg::DWB_ST_DATA
      && ins_q.op == `DWB_OP_WR_WIPER) |=> wiper_q[$past(ins_q.pot)] == $past(byte_w[5:0]))
    else $error("wiper write lost");

  AST_NV_BUSY: assert property ((byte_done && st_q == dwb_pkg::DWB_ST_DATA
      && ins_q.op == `DWB_OP_WR_STORED) |=> busy_q == NV_WRITE_CYCLES)
    else $error("stored write did not start busy time");

  AST_RECALL_COPY: assert property ((byte_done && st_q == dwb_pkg::DWB_ST_INSTR
      && ins_w.op == `DWB_OP_RECALL)
      |=> wiper_q[$past(ins_w.pot)] == $past(stored_q[ins_w.pot][ins_w.idx]))
    else $error("stored setting not copied to wiper");

  AST_INCDEC_UP: assert property ((byte_done && st_q == dwb_pkg::DWB_ST_DATA
      && ins_q.op == `DWB_OP_INCDEC && byte_w[0] && wiper_q[ins_q.pot] != `DWB_WIPER_MAX)
      |=> wiper_q[$past(ins_q.pot)] == $past(wiper_q[ins_q.pot]) + 6'h01)
    else $error("increment did not step wiper");

  function automatic logic sda_o_check(input logic lvl);
    return lvl == 1'b0;
  endfunction : sda_o_check

endmodule : dwb_wiper_bank
